// >>> pbwa_backend_model.sv
`timescale 1ns/1ps
`default_nettype none
// Back-end model: serves qword q as {D+2q+1, D+2q}
module pbwa_backend_model (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [pbwa_pkg::NBAR-1:0] match_i,
    input wire logic high_xfer_n_i,
    output logic ready_n_o,
    output logic [pbwa_pkg::QW_W-1:0] data_o
);
    logic [7:0] qw_reg; // Qword address counter
    // Ready always after reset, so the write buffer drains freely
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ready_n_o <= 1'h1;
            qw_reg <= 8'h0;
        end else begin
            ready_n_o <= 1'h0;
            if (match_i == 2'h0) begin
                qw_reg <= 8'h0; // Fresh transaction restarts at qword 0
            end else if (!high_xfer_n_i) begin
                qw_reg <= qw_reg + 8'h1;
            end // Otherwise hold the qword
        end
    end
    // Scrambled while not ready, so stale data never passes
    assign data_o = {32'hD000_0000 + {23'h0, qw_reg, 1'h1}, 32'hD000_0000 + {23'h0, qw_reg, 1'h0}} ^ {64{ready_n_o}};
endmodule : pbwa_backend_model
`default_nettype wire

// >>> pbwa_bridge.sv
//------------------------------------------------------------------
// Notes on behaviour
// - Qword read: drive dword after two ready cycles
// - Copy-sourced dword pulses low strobe, back-end holds
// - Dword read: high dword after a live low dword from internal copy
// - Live qword load pulses high strobe, back-end advances
// - Turnaround: float data, drop selects, clear match
// - Idle after turnaround: release select and ready
// - Second clock: show captured address to back-end
// - Third clock: window hit drives match output
// - Slow timing: select one clock after match
// - Write: target ready follows prior back-end ready
// - Write qword commit pulses high strobe
//------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module pbwa_bridge (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic frame_n_i,
    input wire logic irdy_n_i,
    input wire logic [pbwa_pkg::BE_W-1:0] cbe_i,
    input wire logic [pbwa_pkg::AD_W-1:0] ad_i,
    output logic [pbwa_pkg::AD_W-1:0] ad_o,
    output logic ad_oe_o,
    output logic devsel_n_o,
    output logic devsel_oe_o,
    output logic trdy_n_o,
    output logic trdy_oe_o,
    input wire logic [pbwa_pkg::TIMING_W-1:0] select_timing_option_i,
    input wire logic [pbwa_pkg::NBAR-1:0][pbwa_pkg::AD_W-1:0] window_base_i,
    input wire logic [pbwa_pkg::NBAR-1:0][pbwa_pkg::AD_W-1:0] window_mask_i,
    input wire logic [pbwa_pkg::NBAR-1:0] window_enable_i,
    output logic [pbwa_pkg::AD_W-1:0] local_addr_out_o,
    output logic [pbwa_pkg::NBAR-1:0] base_window_match_o,
    input wire logic backend_ready_n_i,
    input wire logic [pbwa_pkg::QW_W-1:0] local_read_data_in_i,
    output logic low_dword_xfer_n_o,
    output logic high_dword_xfer_n_o,
    output logic [pbwa_pkg::QW_W-1:0] local_write_data_out_o
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    pbwa_pkg::pbwa_state_t state_reg; // Transaction progress
    logic is_write_reg; // Captured command direction
    logic rdy_d1_reg; // Back-end ready one cycle ago
    logic half_reg; // Next read dword: 1 = high half
    logic [pbwa_pkg::AD_W-1:0] copy_reg; // Held high dword
    logic copy_valid_reg; // Copy not yet sent
    logic loaded_reg; // ad_o holds an unsent dword
    logic wait_reg; // Back-end advancing, live data stale
    logic wr_half_reg; // Next write dword lands high
    logic [pbwa_pkg::NBAR-1:0] hit; // Window decode
    logic rdy_now, xfer, last, live_ok, need_load, rd_active;
    logic load_copy, load_live, load_en, loaded_next, wr_go, pop_ok;
    logic slow_sel; // Slow select timing chosen

    pbwa_fifo_if #(.W(pbwa_pkg::AD_W)) wr_bus ();

    pbwa_fifo #(
        .WIDTH(pbwa_pkg::AD_W),
        .DEPTH(pbwa_pkg::FIFO_DEPTH)
    ) u_wr_fifo (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .port(wr_bus.fifo)
    );

    // ------------------------------------------------------------
    // Handshake terms
    // ------------------------------------------------------------
    assign rdy_now = (backend_ready_n_i == pbwa_pkg::ACT_N);
    assign xfer = (state_reg == pbwa_pkg::ST_DATA) && !irdy_n_i && !trdy_n_o;
    // Frame already high on a transfer marks the final data phase
    assign last = xfer && frame_n_i;
    assign slow_sel = (select_timing_option_i == pbwa_pkg::TIMING_SLOW);
    // Fresh back-end data needs ready for two cycles in a row
    assign live_ok = rdy_now && rdy_d1_reg && !wait_reg;
    assign need_load = !loaded_reg || xfer;
    assign rd_active = (state_reg == pbwa_pkg::ST_DATA) && !is_write_reg && !last;
    assign load_copy = rd_active && need_load && half_reg && copy_valid_reg;
    assign load_live = rd_active && need_load && !(half_reg && copy_valid_reg) && live_ok;
    assign load_en = load_copy || load_live;
    assign loaded_next = load_en || (loaded_reg && !xfer);
    // Stop offering write ready before the buffer can overflow
    assign wr_go = rdy_now && !wr_bus.almost_full && !last;
    assign wr_bus.push_valid = xfer && is_write_reg;
    assign wr_bus.push_data = ad_i;
    assign wr_bus.pop_ready = rdy_now;
    assign pop_ok = wr_bus.pop_valid && wr_bus.pop_ready;

    // Per-window compare, masked bits must equal the base
    for (genvar g = 0; g < pbwa_pkg::NBAR; g++) begin : g_win
        assign hit[g] = window_enable_i[g]
            && (((local_addr_out_o ^ window_base_i[g]) & window_mask_i[g]) == '0);
    end

    // ------------------------------------------------------------
    // Transaction sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_reg <= pbwa_pkg::ST_IDLE;
            is_write_reg <= 1'h0;
        end else begin
            case (state_reg)
                pbwa_pkg::ST_IDLE: begin
                    // Address phase: frame low with address and command
                    if (!frame_n_i) begin
                        is_write_reg <= cbe_i[pbwa_pkg::CMD_WR_BIT];
                        state_reg <= pbwa_pkg::ST_DECODE;
                    end
                end
                pbwa_pkg::ST_DECODE: begin
                    state_reg <= (|hit) ? pbwa_pkg::ST_MATCH : pbwa_pkg::ST_MISS;
                end
                pbwa_pkg::ST_MATCH: begin
                    state_reg <= pbwa_pkg::ST_DATA;
                end
                pbwa_pkg::ST_DATA: begin
                    if (last) begin
                        state_reg <= pbwa_pkg::ST_TURN;
                    end
                end
                pbwa_pkg::ST_TURN: begin
                    state_reg <= pbwa_pkg::ST_IDLE;
                end
                pbwa_pkg::ST_MISS: begin
                    // Not ours: sit out until the bus goes idle
                    if (frame_n_i && irdy_n_i) begin
                        state_reg <= pbwa_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= pbwa_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Address to back-end and window match
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            local_addr_out_o <= pbwa_pkg::AD_RST;
            base_window_match_o <= '0;
        end else begin
            if (state_reg == pbwa_pkg::ST_IDLE && !frame_n_i) begin
                local_addr_out_o <= ad_i;
            end
            if (state_reg == pbwa_pkg::ST_DECODE) begin
                base_window_match_o <= hit;
            end else if (last || state_reg == pbwa_pkg::ST_MISS) begin
                base_window_match_o <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Device select and target ready pins
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            devsel_n_o <= pbwa_pkg::IDLE_N;
            devsel_oe_o <= 1'h0;
            trdy_n_o <= pbwa_pkg::IDLE_N;
            trdy_oe_o <= 1'h0;
        end else begin
            // Fast/medium claim with the match; slow one clock later
            if ((state_reg == pbwa_pkg::ST_DECODE && (|hit) && !slow_sel)
                || (state_reg == pbwa_pkg::ST_MATCH && slow_sel)) begin
                devsel_n_o <= pbwa_pkg::ACT_N;
                devsel_oe_o <= 1'h1;
                trdy_oe_o <= 1'h1;
            end
            if (state_reg == pbwa_pkg::ST_DATA) begin
                if (last) begin
                    devsel_n_o <= pbwa_pkg::IDLE_N;
                    trdy_n_o <= pbwa_pkg::IDLE_N;
                end else if (is_write_reg) begin
                    trdy_n_o <= wr_go ? pbwa_pkg::ACT_N : pbwa_pkg::IDLE_N;
                end else begin
                    trdy_n_o <= loaded_next ? pbwa_pkg::ACT_N : pbwa_pkg::IDLE_N;
                end
            end
            if (state_reg == pbwa_pkg::ST_TURN) begin
                devsel_oe_o <= 1'h0;
                trdy_oe_o <= 1'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Read dword steering onto the bus
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ad_o <= pbwa_pkg::AD_RST;
            ad_oe_o <= 1'h0;
            half_reg <= 1'h0;
            copy_reg <= pbwa_pkg::AD_RST;
            copy_valid_reg <= 1'h0;
            loaded_reg <= 1'h0;
            wait_reg <= 1'h0;
        end else begin
            if (state_reg == pbwa_pkg::ST_MATCH) begin
                // Start alignment comes from the captured address
                half_reg <= local_addr_out_o[pbwa_pkg::ADDR_QW_BIT];
                copy_valid_reg <= 1'h0;
                loaded_reg <= 1'h0;
                ad_oe_o <= !is_write_reg;
            end else begin
                loaded_reg <= loaded_next;
            end
            if (last) begin
                ad_oe_o <= 1'h0;
            end
            // One cycle of wait lets the back-end step its qword
            wait_reg <= load_live;
            if (load_copy) begin
                ad_o <= copy_reg;
                copy_valid_reg <= 1'h0;
                half_reg <= 1'h0;
            end else if (load_live) begin
                half_reg <= !half_reg;
                if (half_reg) begin
                    // Dword-aligned start: low half is discarded
                    ad_o <= local_read_data_in_i[pbwa_pkg::QW_W-1:pbwa_pkg::HI_LSB];
                end else begin
                    ad_o <= local_read_data_in_i[pbwa_pkg::LO_MSB:0];
                    copy_reg <= local_read_data_in_i[pbwa_pkg::QW_W-1:pbwa_pkg::HI_LSB];
                    copy_valid_reg <= 1'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Write qword assembly from the buffer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            local_write_data_out_o <= pbwa_pkg::QW_RST;
            wr_half_reg <= 1'h0;
        end else begin
            // Realigned per transaction; assumes the buffer drained
            if (state_reg == pbwa_pkg::ST_MATCH && !wr_bus.pop_valid) begin
                wr_half_reg <= local_addr_out_o[pbwa_pkg::ADDR_QW_BIT];
            end else if (pop_ok) begin
                wr_half_reg <= !wr_half_reg;
                if (wr_half_reg) begin
                    local_write_data_out_o[pbwa_pkg::QW_W-1:pbwa_pkg::HI_LSB] <= wr_bus.pop_data;
                end else begin
                    local_write_data_out_o[pbwa_pkg::LO_MSB:0] <= wr_bus.pop_data;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Back-end transfer strobes, one-cycle low pulses
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            low_dword_xfer_n_o <= pbwa_pkg::IDLE_N;
            high_dword_xfer_n_o <= pbwa_pkg::IDLE_N;
        end else begin
            // High pulse: qword consumed, back-end may advance
            high_dword_xfer_n_o <= (load_live || (pop_ok && wr_half_reg))
                ? pbwa_pkg::ACT_N : pbwa_pkg::IDLE_N;
            // Low pulse: held copy or low write half, back-end holds
            low_dword_xfer_n_o <= (load_copy || (pop_ok && !wr_half_reg))
                ? pbwa_pkg::ACT_N : pbwa_pkg::IDLE_N;
        end
    end

    // Back-end ready history
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rdy_d1_reg <= 1'h0;
        end else begin
            rdy_d1_reg <= rdy_now;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_turn;
        state_reg == pbwa_pkg::ST_TURN;
    endsequence
    sequence s_addr_phase;
        state_reg == pbwa_pkg::ST_IDLE && !frame_n_i;
    endsequence

    AST_READ_TWO_READY: assert property (
        $fell(trdy_n_o) && !is_write_reg |-> $past(rdy_now, 1) && $past(rdy_now, 2))
        else $error("read ready without two back-end ready cycles");
    AST_COPY_DWORD: assert property (load_copy |=> ad_o == $past(copy_reg))
        else $error("copied dword not driven");
    AST_LIVE_STROBE: assert property (load_live |=> !high_dword_xfer_n_o ##1 high_dword_xfer_n_o)
        else $error("high strobe missing after live load");
    AST_TURN_FLOAT: assert property (s_turn |-> !ad_oe_o && devsel_n_o && trdy_n_o
        && base_window_match_o == '0 && high_dword_xfer_n_o)
        else $error("turnaround did not release bus");
    AST_IDLE_RELEASE: assert property (s_turn |=> !devsel_oe_o && !trdy_oe_o)
        else $error("select still driven after turnaround");
    AST_ADDR_SHOWN: assert property (s_addr_phase |=> local_addr_out_o == $past(ad_i))
        else $error("address not presented in second clock");
    AST_MATCH_THIRD: assert property (s_addr_phase ##1 (|hit) |=> base_window_match_o == $past(hit))
        else $error("window match not in third clock");
    AST_SLOW_SELECT: assert property (
        slow_sel && $rose(|base_window_match_o) |-> devsel_n_o ##1 !devsel_n_o)
        else $error("slow select not one clock after match");
    AST_WRITE_READY: assert property (
        $fell(trdy_n_o) && is_write_reg |-> $past(rdy_now))
        else $error("write ready without prior back-end ready");
    AST_WRITE_COMMIT: assert property (pop_ok && wr_half_reg |=> !high_dword_xfer_n_o)
        else $error("write qword commit strobe missing");
endmodule : pbwa_bridge
`default_nettype wire

// >>> pbwa_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module pbwa_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    pbwa_fifo_if.fifo port
);
    // Depth must be a power of two: pointers wrap by overflow
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
    localparam logic [AW:0] CNT_ALMOST = (AW+1)'(DEPTH - 1);
    localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
    localparam logic [AW-1:0] PTR_ONE = AW'(1);

    logic [WIDTH-1:0] mem_reg [DEPTH]; // Storage
    logic [AW-1:0] wr_ptr_reg; // Next slot to fill
    logic [AW-1:0] rd_ptr_reg; // Next slot to drain
    logic [AW:0] count_reg; // Occupancy
    logic push_ok; // Accepted write
    logic pop_ok; // Accepted read

    assign push_ok = port.push_valid & port.push_ready;
    assign pop_ok = port.pop_valid & port.pop_ready;
    assign port.push_ready = (count_reg != CNT_FULL);
    assign port.almost_full = (count_reg >= CNT_ALMOST);
    assign port.pop_valid = (count_reg != '0);
    assign port.pop_data = mem_reg[rd_ptr_reg];

    // ------------------------------------------------------------
    // Storage, no reset needed on data
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (push_ok) begin
            mem_reg[wr_ptr_reg] <= port.push_data;
        end
    end

    // ------------------------------------------------------------
    // Pointers and occupancy
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push_ok) begin
                wr_ptr_reg <= wr_ptr_reg + PTR_ONE;
            end
            if (pop_ok) begin
                rd_ptr_reg <= rd_ptr_reg + PTR_ONE;
            end
            // Simultaneous push and pop leaves the count alone
            if (push_ok && !pop_ok) begin
                count_reg <= count_reg + CNT_ONE;
            end else if (pop_ok && !push_ok) begin
                count_reg <= count_reg - CNT_ONE;
            end
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_FIFO_BOUND: assert property (count_reg <= CNT_FULL)
        else $error("fifo occupancy above depth");
    AST_FIFO_FILL: assert property (push_ok && !pop_ok |=> count_reg == $past(count_reg) + CNT_ONE)
        else $error("fifo count did not rise on push");
endmodule : pbwa_fifo
`default_nettype wire

// >>> pbwa_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none
// Write buffer carrier between the bridge and its FIFO
interface pbwa_fifo_if #(parameter int W = 32);
    logic push_valid; // Dword offered
    logic push_ready; // Room for one more
    logic almost_full; // One slot or less left
    logic [W-1:0] push_data; // Dword in
    logic pop_valid; // Dword available
    logic pop_ready; // Drain side takes it
    logic [W-1:0] pop_data; // Dword out
    modport fifo (input push_valid, push_data, pop_ready,
                  output push_ready, almost_full, pop_valid, pop_data);
    modport user (output push_valid, push_data, pop_ready,
                  input push_ready, almost_full, pop_valid, pop_data);
endinterface : pbwa_fifo_if
`default_nettype wire

// >>> pbwa_pkg.sv
`default_nettype none
package pbwa_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int AD_W = 32; // Bus address/data width
    localparam int QW_W = 64; // Back-end qword width
    localparam int BE_W = 4; // Command/byte-enable width
    localparam int NBAR = 2; // Number of decode windows
    localparam int FIFO_DEPTH = 16; // Write buffer depth in dwords
    localparam int TIMING_W = 2; // Select timing option width

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CMD_WR_BIT = 0; // Command bit 0 set means write
    localparam int ADDR_QW_BIT = 2; // Dword-within-qword address bit
    localparam int LO_MSB = 31; // Low dword of a qword
    localparam int HI_LSB = 32; // High dword of a qword

    // ------------------------------------------------------------
    // Select timing encodings
    // ------------------------------------------------------------
    localparam logic [TIMING_W-1:0] TIMING_FAST = 2'h0;
    localparam logic [TIMING_W-1:0] TIMING_MEDIUM = 2'h1;
    localparam logic [TIMING_W-1:0] TIMING_SLOW = 2'h2;

    // ------------------------------------------------------------
    // Signal levels and reset values
    // ------------------------------------------------------------
    localparam logic ACT_N = 1'h0; // Asserted level of _n signals
    localparam logic IDLE_N = 1'h1; // Released level of _n signals
    localparam logic [AD_W-1:0] AD_RST = 32'h0000_0000;
    localparam logic [QW_W-1:0] QW_RST = 64'h0000_0000_0000_0000;

    // Target transaction progress
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DECODE,
        ST_MATCH,
        ST_DATA,
        ST_TURN,
        ST_MISS
    } pbwa_state_t;
endpackage : pbwa_pkg
`default_nettype wire

// >>> pci_target_burst_width_adapter_test.sv
`timescale 1ns/1ps
`default_nettype none
module pci_target_burst_width_adapter_test;
    logic clk = 1'h0, rst_n = 1'h0, frame_n = 1'h1, irdy_n = 1'h1;
    logic [3:0] cbe = 4'h0;
    logic [31:0] ad_in = 32'h0, ad_o, addr_out;
    logic [1:0] timing = 2'h2, match;
    logic ad_oe, dsel_n, dsel_oe, trdy_n, trdy_oe, rdy_n, lo_n, hi_n;
    logic [63:0] rd_data, wr_out;
    logic [31:0] got [0:3]; // Read dwords seen on the bus
    int bad_count = 0, comparisons = 0, cycles = 0;
    int lo_count = 0, hi_count = 0; // Strobe pulses seen since a scenario began
    // ---------------- Clock and hang guard ----------------
    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (!lo_n) lo_count++;
        if (!hi_n) hi_count++;
        if (cycles == 3000) begin
            bad_count++;
            print_verdict();
        end
    end
    pbwa_bridge DUT (.core_clk_i(clk), .rst_n_i(rst_n), .frame_n_i(frame_n), .irdy_n_i(irdy_n), .cbe_i(cbe),
        .ad_i(ad_in), .ad_o(ad_o), .ad_oe_o(ad_oe), .devsel_n_o(dsel_n), .devsel_oe_o(dsel_oe),
        .trdy_n_o(trdy_n), .trdy_oe_o(trdy_oe), .select_timing_option_i(timing),
        .window_base_i({32'h2000_0000, 32'h1000_0000}), .window_mask_i({32'hF000_0000, 32'hF000_0000}),
        .window_enable_i(2'h3), .local_addr_out_o(addr_out), .base_window_match_o(match),
        .backend_ready_n_i(rdy_n), .local_read_data_in_i(rd_data), .low_dword_xfer_n_o(lo_n),
        .high_dword_xfer_n_o(hi_n), .local_write_data_out_o(wr_out));
    pbwa_backend_model partner (.core_clk_i(clk), .rst_n_i(rst_n), .match_i(match), .high_xfer_n_i(hi_n),
        .ready_n_o(rdy_n), .data_o(rd_data));
    // ---------------- Shared tasks ----------------
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Master side of one burst of n data phases
    task automatic burst(input logic [31:0] addr, input logic wr, input logic [1:0] hit, input int n);
        int k;
        int w;
        k = 0;
        w = 0;
        @(negedge clk);
        frame_n = 1'h0; // Address phase
        ad_in = addr;
        cbe = {3'h3, wr};
        @(negedge clk);
        irdy_n = 1'h0;
        frame_n = (n == 1);
        ad_in = 32'h5000_0000;
        cbe = 4'h0;
        check("local_addr", addr_out, addr);
        @(negedge clk);
        check("match", match, hit);
        check("early_select", dsel_n, timing == pbwa_pkg::TIMING_SLOW);
        while (k < n && w < 40) begin
            @(posedge clk);
            w++;
            if (trdy_n === 1'h0) begin
                got[k] = ad_o;
                k++;
            end
            @(negedge clk);
            if (timing == pbwa_pkg::TIMING_SLOW && w == 1) check("slow_select", dsel_n, 1'h0);
            frame_n = (k >= n - 1); // Frame ends the burst
            ad_in = 32'h5000_0000 + k;
            if (k == n) irdy_n = 1'h1;
        end
        check("turn_state", {dsel_n, trdy_n, ad_oe, match}, {3'h6, 2'h0});
        @(negedge clk);
        check("idle_release", {dsel_oe, trdy_oe}, 2'h0);
    endtask : burst
    // ---------------- Scenarios ----------------
    task automatic read_test(input logic [1:0] opt, input logic [31:0] addr);
        int j;
        timing = opt;
        lo_count = 0;
        hi_count = 0;
        burst(addr, 1'h0, 2'h2, 3);
        for (j = 0; j < 3; j++) check("read_dword", got[j], 32'hD000_0000 + addr[2] + j);
        // Three dwords in either alignment: two live qwords, one held copy
        check("read_low_strobes", lo_count, 1);
        check("read_high_strobes", hi_count, 2);
        $display("read test at %h done", addr);
    endtask : read_test
    task automatic write_test();
        int w;
        timing = pbwa_pkg::TIMING_MEDIUM;
        lo_count = 0;
        hi_count = 0;
        burst(32'h1000_0000, 1'h1, 2'h1, 2);
        for (w = 0; w < 20 && hi_count == 0; w++) @(negedge clk);
        check("write_qword", wr_out, 64'h5000_0001_5000_0000);
        // Aligned pair: low half marked first, then one qword commit
        check("write_low_strobe", lo_count, 1);
        check("write_high_strobe", hi_count, 1);
        $display("write test done");
    endtask : write_test
    task automatic miss_test();
        int w;
        lo_count = 0;
        hi_count = 0;
        @(negedge clk);
        frame_n = 1'h0;
        ad_in = 32'h3000_0000;
        cbe = 4'h6;
        @(negedge clk);
        frame_n = 1'h1;
        irdy_n = 1'h0;
        for (w = 0; w < 4; w++) begin
            @(negedge clk);
            check("miss_quiet", {dsel_oe, trdy_oe, match}, 4'h0);
        end
        irdy_n = 1'h1;
        @(negedge clk);
        // A missed address must never reach the back-end strobes
        check("miss_strobes", lo_count + hi_count, 0);
        $display("miss test done");
    endtask : miss_test
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'h1;
        @(negedge clk);
        read_test(pbwa_pkg::TIMING_SLOW, 32'h2000_0010);
        read_test(pbwa_pkg::TIMING_FAST, 32'h2000_0004);
        write_test();
        miss_test();
        print_verdict();
    end
endmodule : pci_target_burst_width_adapter_test
`default_nettype wire
